//--- rwsup_pkg.sv
// Package for the reset and watchdog supervisor: map, fields, timing
package rwsup_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] ADDR_SYS_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_DEBUG_FLG  = 8'h04;
   localparam logic [7:0] ADDR_WD_CTRL    = 8'h08;
   localparam logic [7:0] ADDR_WD_RESTART = 8'h0c;
   localparam logic [7:0] ADDR_BO_CTRL    = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT   = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
   localparam logic [7:0] ADDR_RST_CAUSE  = 8'h1c;

   // System control fields
   localparam int SC_IRQ_BIT  = 0;
   localparam int SC_PWL_BIT  = 1;
   localparam logic [31:0] SC_RESET = 32'h0000_0002;
   localparam int DBG_SPE_BIT = 0;

   // Watchdog control fields
   localparam int WD_EN_BIT   = 0;
   localparam int WD_RST_EN_BIT = 1;
   localparam int WD_SEL_LO   = 2;

   // Interrupt status / mask layout
   localparam int IRQ_WD      = 0;
   localparam int IRQ_BO_CORE = 1;
   localparam int IRQ_BO_ANA  = 2;
   localparam int IRQ_BO_IO   = 3;
   localparam int IRQ_W       = 4;

   // Reset cause layout
   localparam int CAUSE_POR   = 0;
   localparam int CAUSE_WD    = 1;
   localparam int CAUSE_EXT   = 2;
   localparam int CAUSE_SW    = 3;

   // Timing
   localparam int WD_WIN_CYC    = 512;
   localparam int WD_RST_CYC    = 8;
   localparam int EXT_MIN_CYC   = 4;
   localparam int POR_DELAY_DEF = 65536;
   localparam int WD_CNT_W      = 22;
   localparam logic [15:0] RESET_VECTOR = 16'h8000;

   // Interval lengths in RC cycles: 2^12, 2^15, 2^18, 2^21
   localparam int WD_EXP0 = 12;
   localparam int WD_EXP_STEP = 3;

   typedef enum logic [1:0] {
      RWSUP_WD_IDLE   = 2'b00,
      RWSUP_WD_COUNT  = 2'b01,
      RWSUP_WD_WINDOW = 2'b10,
      RWSUP_WD_RESET  = 2'b11
   } rwsup_wd_state_t;

   typedef struct packed {
      logic core;
      logic analog;
      logic io;
   } rwsup_supply_t;

endpackage

//--- rwsup_top.sv
// Reset merging, power-on delay, watchdog and brownout alerts
`timescale 1ns/1ns

module rwsup_top #(
   parameter int POR_DELAY = rwsup_pkg::POR_DELAY_DEF
) (
   input  wire logic                  REF_CLK,
   input  wire logic                  SRST,
   input  wire logic                  RC_CLK,
   input  wire logic                  CORE_SUPPLY_OK,
   input  wire logic                  RESET_N_IN,
   output logic                       RESET_N_OUT,
   output logic                       RESET_N_OE,
   input  wire rwsup_pkg::rwsup_supply_t BO_LOW,
   output logic                       RC_OSC_EN,
   output logic                       CORE_RUN,
   output logic                       IO_DEFAULT,
   output logic [15:0]                FETCH_ADDR,
   output logic                       IRQ,
   input  wire logic [7:0]            S_AXI_AWADDR,
   input  wire logic                  S_AXI_AWVALID,
   output logic                       S_AXI_AWREADY,
   input  wire logic [31:0]           S_AXI_WDATA,
   input  wire logic [3:0]            S_AXI_WSTRB,
   input  wire logic                  S_AXI_WVALID,
   output logic                       S_AXI_WREADY,
   output logic [1:0]                 S_AXI_BRESP,
   output logic                       S_AXI_BVALID,
   input  wire logic                  S_AXI_BREADY,
   input  wire logic [7:0]            S_AXI_ARADDR,
   input  wire logic                  S_AXI_ARVALID,
   output logic                       S_AXI_ARREADY,
   output logic [31:0]                S_AXI_RDATA,
   output logic [1:0]                 S_AXI_RRESP,
   output logic                       S_AXI_RVALID,
   input  wire logic                  S_AXI_RREADY
);

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'b00) && (a <= rwsup_pkg::ADDR_RST_CAUSE);
   endfunction

   // System-clock domain state
   logic [31:0]          sys_ctrl_ff;
   logic                 spe_ff;
   logic [3:0]           wd_ctrl_ff;
   logic [2:0]           bo_en_ff;
   logic [3:0]           irq_stat_ff;
   logic [3:0]           irq_mask_ff;
   logic [3:0]           cause_ff;
   logic [31:0]          por_cnt_ff;
   logic                 por_done_ff;
   logic                 ext_s1_ff;
   logic                 ext_s2_ff;
   logic [2:0]           ext_low_cnt_ff;
   logic                 ext_rst_ff;
   logic                 sw_rst_ff;
   logic                 restart_tgl_ff;
   logic                 aw_hold_ff;
   logic                 w_hold_ff;
   logic [7:0]           awaddr_ff;
   logic [31:0]          wdata_ff;
   logic                 bvalid_ff;
   logic [1:0]           bresp_ff;
   logic                 rvalid_ff;
   logic [31:0]          rdata_ff;
   logic [1:0]           rresp_ff;
   logic                 own1_ff;
   logic                 own2_ff;
   logic                 wirq1_ff;
   logic                 wirq2_ff;
   logic                 wirq3_ff;
   logic                 wrst1_ff;
   logic                 wrst2_ff;
   logic                 wrst3_ff;
   logic                 reset_ff;

   // RC-domain state
   rwsup_pkg::rwsup_wd_state_t wd_state_ff;
   logic [rwsup_pkg::WD_CNT_W-1:0] wd_cnt_ff;
   logic                 wd_irq_tgl_ff;
   logic                 wd_rst_lvl_ff;
   logic                 rc_en1_ff;
   logic                 rc_en2_ff;
   logic                 rc_rst1_ff;
   logic                 rc_rst2_ff;
   logic [1:0]           rc_sel1_ff;
   logic [1:0]           rc_sel2_ff;
   logic                 rc_re1_ff;
   logic                 rc_re2_ff;
   logic                 rc_t1_ff;
   logic                 rc_t2_ff;
   logic                 rc_t3_ff;

   logic                 wr_go;
   logic                 rd_go;
   logic [7:0]           wr_addr;
   logic [31:0]          wr_data;
   logic [3:0]           ev_set;
   logic                 any_reset;
   logic                 restart_wr;
   logic [rwsup_pkg::WD_CNT_W-1:0] wd_limit;

   assign wr_addr = aw_hold_ff ? awaddr_ff : S_AXI_AWADDR;
   assign wr_data = w_hold_ff ? wdata_ff : S_AXI_WDATA;
   assign S_AXI_AWREADY = !aw_hold_ff && !bvalid_ff;
   assign S_AXI_WREADY  = !w_hold_ff && !bvalid_ff;
   assign wr_go = !bvalid_ff && (aw_hold_ff || S_AXI_AWVALID)
                  && (w_hold_ff || S_AXI_WVALID);
   assign S_AXI_ARREADY = !rvalid_ff;
   assign rd_go = S_AXI_ARVALID && !rvalid_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP  = bresp_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA  = rdata_ff;
   assign S_AXI_RRESP  = rresp_ff;
   assign restart_wr = wr_go && wr_addr == rwsup_pkg::ADDR_WD_RESTART;

   // Write channel: address and data may arrive in either order
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 32'h0000_0000;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= 2'b00;
      end
      else
      begin
         if (wr_go)
         begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= is_mapped(wr_addr) ? 2'b00 : 2'b10;
         end
         else
         begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
               aw_hold_ff <= 1'b1;
               awaddr_ff  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
               w_hold_ff <= 1'b1;
               wdata_ff  <= S_AXI_WDATA;
            end
            if (bvalid_ff && S_AXI_BREADY)
               bvalid_ff <= 1'b0;
         end
      end
   end

   // Control registers; software reset clears them too
   always_ff @(posedge REF_CLK)
   begin
      if (SRST || reset_ff)
      begin
         sys_ctrl_ff <= rwsup_pkg::SC_RESET;
         spe_ff      <= 1'b0;
         wd_ctrl_ff  <= 4'h0;
         bo_en_ff    <= 3'b000;
         irq_mask_ff <= 4'h0;
      end
      else if (wr_go)
      begin
         case (wr_addr)
            rwsup_pkg::ADDR_SYS_CTRL:
               sys_ctrl_ff[rwsup_pkg::SC_PWL_BIT] <=
                  wr_data[rwsup_pkg::SC_PWL_BIT];
            rwsup_pkg::ADDR_DEBUG_FLG:
               spe_ff <= wr_data[rwsup_pkg::DBG_SPE_BIT];
            rwsup_pkg::ADDR_WD_CTRL: wd_ctrl_ff <= wr_data[3:0];
            rwsup_pkg::ADDR_BO_CTRL: bo_en_ff <= wr_data[2:0];
            rwsup_pkg::ADDR_IRQ_MASK: irq_mask_ff <= wr_data[3:0];
            default: ;
         endcase
      end
   end

   // Internal reset request, honoured only with program enable set
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
         sw_rst_ff <= 1'b0;
      else
         sw_rst_ff <= wr_go && wr_addr == rwsup_pkg::ADDR_SYS_CTRL
                      && wr_data[rwsup_pkg::SC_IRQ_BIT] && spe_ff;
   end

   // Brownout and watchdog events; set wins over write-one-clear
   assign ev_set[rwsup_pkg::IRQ_WD] = wirq3_ff ^ wirq2_ff;
   assign ev_set[rwsup_pkg::IRQ_BO_CORE] = bo_en_ff[2] && BO_LOW.core;
   assign ev_set[rwsup_pkg::IRQ_BO_ANA]  = bo_en_ff[1] && BO_LOW.analog;
   assign ev_set[rwsup_pkg::IRQ_BO_IO]   = bo_en_ff[0] && BO_LOW.io;

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
         irq_stat_ff <= 4'h0;
      else if (wr_go && wr_addr == rwsup_pkg::ADDR_IRQ_STAT)
         irq_stat_ff <= (irq_stat_ff & ~wr_data[3:0]) | ev_set;
      else
         irq_stat_ff <= irq_stat_ff | ev_set;
   end

   assign IRQ = |(irq_stat_ff & irq_mask_ff);

   // Read channel
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= 2'b00;
      end
      else if (rd_go)
      begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= is_mapped(S_AXI_ARADDR) ? 2'b00 : 2'b10;
         case (S_AXI_ARADDR)
            rwsup_pkg::ADDR_SYS_CTRL:  rdata_ff <= sys_ctrl_ff;
            rwsup_pkg::ADDR_DEBUG_FLG: rdata_ff <= {31'h0, spe_ff};
            rwsup_pkg::ADDR_WD_CTRL:   rdata_ff <= {28'h0, wd_ctrl_ff};
            rwsup_pkg::ADDR_BO_CTRL:   rdata_ff <= {29'h0, bo_en_ff};
            rwsup_pkg::ADDR_IRQ_STAT:  rdata_ff <= {28'h0, irq_stat_ff};
            rwsup_pkg::ADDR_IRQ_MASK:  rdata_ff <= {28'h0, irq_mask_ff};
            rwsup_pkg::ADDR_RST_CAUSE: rdata_ff <= {28'h0, cause_ff};
            default:                   rdata_ff <= 32'h0000_0000;
         endcase
      end
      else if (rvalid_ff && S_AXI_RREADY)
         rvalid_ff <= 1'b0;
   end

   // Power-on delay from core supply good
   always_ff @(posedge REF_CLK)
   begin
      if (SRST || !CORE_SUPPLY_OK)
      begin
         por_cnt_ff  <= 32'h0000_0000;
         por_done_ff <= 1'b0;
      end
      else if (!por_done_ff)
      begin
         por_cnt_ff  <= por_cnt_ff + 32'h0000_0001;
         por_done_ff <= (por_cnt_ff == 32'(POR_DELAY - 1));
      end
   end

   // Pin is sampled twice before the low-time qualifier looks at it
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         ext_s1_ff      <= 1'b1;
         ext_s2_ff      <= 1'b1;
         own1_ff        <= 1'b0;
         own2_ff        <= 1'b0;
         ext_low_cnt_ff <= 3'h0;
         ext_rst_ff     <= 1'b0;
      end
      else
      begin
         ext_s1_ff <= RESET_N_IN;
         ext_s2_ff <= ext_s1_ff;
         // Our own pull shows on the pin too; delayed like the pin so that
         // it never passes for an external reset or overwrites the cause
         own1_ff   <= RESET_N_OE;
         own2_ff   <= own1_ff;
         if (ext_s2_ff || own2_ff)
         begin
            ext_low_cnt_ff <= 3'h0;
            ext_rst_ff     <= 1'b0;
         end
         else if (ext_low_cnt_ff != 3'(rwsup_pkg::EXT_MIN_CYC - 1))
            ext_low_cnt_ff <= ext_low_cnt_ff + 3'h1;
         else
            ext_rst_ff <= 1'b1;
      end
   end

   // Watchdog reset level crossing from the RC domain
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         wrst1_ff <= 1'b0;
         wrst2_ff <= 1'b0;
         wrst3_ff <= 1'b0;
         wirq1_ff <= 1'b0;
         wirq2_ff <= 1'b0;
         wirq3_ff <= 1'b0;
         restart_tgl_ff <= 1'b0;
      end
      else
      begin
         wrst1_ff <= wd_rst_lvl_ff;
         wrst2_ff <= wrst1_ff;
         wrst3_ff <= wrst2_ff;
         wirq1_ff <= wd_irq_tgl_ff;
         wirq2_ff <= wirq1_ff;
         wirq3_ff <= wirq2_ff;
         if (restart_wr)
            restart_tgl_ff <= ~restart_tgl_ff;
      end
   end

   assign any_reset = !por_done_ff || wrst2_ff || ext_rst_ff
                      || sw_rst_ff;

   // Merged reset and cause flags; SRST models power-up
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         reset_ff <= 1'b1;
         cause_ff <= 4'h1;
      end
      else
      begin
         reset_ff <= any_reset;
         if (!por_done_ff)
            cause_ff <= 4'h1;
         else
         begin
            if (wrst2_ff && !wrst3_ff)
               cause_ff <= 4'h2;
            if (ext_rst_ff)
               cause_ff <= 4'h4;
            if (sw_rst_ff)
               cause_ff <= 4'h8;
         end
      end
   end

   // Pin drive: pulled low by us only for internal sources
   assign RESET_N_OUT = 1'b0;
   assign RESET_N_OE  = !por_done_ff || wrst2_ff || sw_rst_ff;
   assign RC_OSC_EN   = por_done_ff;
   assign CORE_RUN    = !reset_ff && ext_s2_ff;
   assign IO_DEFAULT  = reset_ff;
   assign FETCH_ADDR  = rwsup_pkg::RESET_VECTOR;

   // RC domain: settings and restart come in over synchronisers
   always_ff @(posedge RC_CLK)
   begin
      rc_en1_ff  <= wd_ctrl_ff[rwsup_pkg::WD_EN_BIT];
      rc_en2_ff  <= rc_en1_ff;
      rc_re1_ff  <= wd_ctrl_ff[rwsup_pkg::WD_RST_EN_BIT];
      rc_re2_ff  <= rc_re1_ff;
      rc_sel1_ff <= wd_ctrl_ff[rwsup_pkg::WD_SEL_LO +: 2];
      rc_sel2_ff <= rc_sel1_ff;
      rc_rst1_ff <= SRST;
      rc_rst2_ff <= rc_rst1_ff;
      rc_t1_ff   <= restart_tgl_ff;
      rc_t2_ff   <= rc_t1_ff;
      rc_t3_ff   <= rc_t2_ff;
   end

   assign wd_limit = rwsup_pkg::WD_CNT_W'(1) <<
      (rwsup_pkg::WD_EXP0 + rwsup_pkg::WD_EXP_STEP * int'(rc_sel2_ff));

   always_ff @(posedge RC_CLK)
   begin
      if (rc_rst2_ff)
      begin
         wd_state_ff   <= rwsup_pkg::RWSUP_WD_IDLE;
         wd_cnt_ff     <= '0;
         wd_irq_tgl_ff <= 1'b0;
         wd_rst_lvl_ff <= 1'b0;
      end
      else if (rc_t3_ff != rc_t2_ff && wd_state_ff != rwsup_pkg::RWSUP_WD_RESET)
      begin
         wd_cnt_ff   <= '0;
         wd_state_ff <= rc_en2_ff ? rwsup_pkg::RWSUP_WD_COUNT
                                  : rwsup_pkg::RWSUP_WD_IDLE;
      end
      else
      begin
         case (wd_state_ff)
            rwsup_pkg::RWSUP_WD_IDLE:
            begin
               wd_cnt_ff <= '0;
               if (rc_en2_ff)
                  wd_state_ff <= rwsup_pkg::RWSUP_WD_COUNT;
            end
            rwsup_pkg::RWSUP_WD_COUNT:
            begin
               if (!rc_en2_ff)
                  wd_state_ff <= rwsup_pkg::RWSUP_WD_IDLE;
               else if (wd_cnt_ff == wd_limit - 1'b1)
               begin
                  wd_irq_tgl_ff <= ~wd_irq_tgl_ff;
                  wd_cnt_ff     <= '0;
                  wd_state_ff   <= rwsup_pkg::RWSUP_WD_WINDOW;
               end
               else
                  wd_cnt_ff <= wd_cnt_ff + 1'b1;
            end
            rwsup_pkg::RWSUP_WD_WINDOW:
            begin
               if (!rc_en2_ff)
                  wd_state_ff <= rwsup_pkg::RWSUP_WD_IDLE;
               else if (wd_cnt_ff ==
                        rwsup_pkg::WD_CNT_W'(rwsup_pkg::WD_WIN_CYC - 1))
               begin
                  wd_cnt_ff   <= '0;
                  wd_rst_lvl_ff <= rc_re2_ff;
                  wd_state_ff <= rc_re2_ff ? rwsup_pkg::RWSUP_WD_RESET
                                           : rwsup_pkg::RWSUP_WD_COUNT;
               end
               else
                  wd_cnt_ff <= wd_cnt_ff + 1'b1;
            end
            rwsup_pkg::RWSUP_WD_RESET:
            begin
               if (wd_cnt_ff ==
                   rwsup_pkg::WD_CNT_W'(rwsup_pkg::WD_RST_CYC - 1))
               begin
                  wd_rst_lvl_ff <= 1'b0;
                  wd_cnt_ff     <= '0;
                  wd_state_ff   <= rwsup_pkg::RWSUP_WD_IDLE;
               end
               else
                  wd_cnt_ff <= wd_cnt_ff + 1'b1;
            end
            default: wd_state_ff <= rwsup_pkg::RWSUP_WD_IDLE;
         endcase
      end
   end

endmodule

//--- rwsup_props.sv
// Port-level checker for the reset and watchdog supervisor
`timescale 1ns/1ns
module rwsup_props #(
   parameter int POR_DELAY = 16
) (
   input wire logic        REF_CLK,
   input wire logic        SRST,
   input wire logic        CORE_SUPPLY_OK,
   input wire logic        RESET_N_IN,
   input wire logic        RESET_N_OE,
   input wire logic        CORE_RUN,
   input wire logic        IO_DEFAULT,
   input wire logic        RC_OSC_EN,
   input wire logic [15:0] FETCH_ADDR,
   input wire logic        IRQ,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID
);
   int por_cnt_ff;
   int low_cnt_ff;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   // Both counts saturate so a long run never wraps them
   always_ff @(posedge REF_CLK)
   begin
      if (SRST || !CORE_SUPPLY_OK) por_cnt_ff <= 0;
      else if (por_cnt_ff < POR_DELAY + 4) por_cnt_ff <= por_cnt_ff + 1;
   end
   always_ff @(posedge REF_CLK)
   begin
      if (RESET_N_IN) low_cnt_ff <= 0;
      else if (low_cnt_ff < 15) low_cnt_ff <= low_cnt_ff + 1;
   end
   a_vector_fixed: assert property (FETCH_ADDR == 16'h8000)
      else $error("fetch address is not the reset vector");
   a_reset_state: assert property (disable iff (1'b0) SRST |=>
      RESET_N_OE && IO_DEFAULT && !CORE_RUN && !IRQ)
      else $error("outputs not in reset state during reset");
   a_por_delay: assert property (por_cnt_ff < POR_DELAY - 1 |-> RESET_N_OE)
      else $error("power-on delay ended early");
   a_por_done: assert property (por_cnt_ff == POR_DELAY + 3 |->
      !RESET_N_OE && RC_OSC_EN)
      else $error("power-on delay did not end");
   a_osc_run: assert property ($fell(RESET_N_OE) |-> ##[0:2] RC_OSC_EN)
      else $error("oscillator not started after reset");
   a_pin_halts: assert property (!RESET_N_IN |-> ##[1:3] !CORE_RUN)
      else $error("core runs while reset pin low");
   a_ext_reset: assert property (low_cnt_ff >= 8 |-> IO_DEFAULT)
      else $error("long pin low gave no reset");
   a_write_refused: assert property (S_AXI_BVALID |->
      !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted while response pending");
   a_read_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read accepted while data pending");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
      S_AXI_RVALID)
      else $error("read data late");
endmodule
bind rwsup_top rwsup_props #(.POR_DELAY(POR_DELAY)) rwsup_props_inst (
   .REF_CLK, .SRST, .CORE_SUPPLY_OK, .RESET_N_IN, .RESET_N_OE, .CORE_RUN,
   .IO_DEFAULT, .RC_OSC_EN, .FETCH_ADDR, .IRQ, .S_AXI_AWREADY, .S_AXI_WREADY,
   .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID);

//--- rwsup_far_model.sv
// Far side: free-running RC oscillator, pull-up and board reset driver
`timescale 1ns/1ns
module rwsup_far_model #(
   parameter int RC_HALF = 37
) (
   input wire logic RESET_N_OE,
   input wire logic ext_pull,
   output logic     rc_clk,
   output logic     pin_n
);
   // Odd start offset keeps it out of phase with the system clock
   initial
   begin
      rc_clk = 1'b0;
      #3;
      forever #(RC_HALF) rc_clk = ~rc_clk;
   end
   // Open drain: any party pulling wins, otherwise the pull-up
   assign pin_n = (RESET_N_OE || ext_pull) ? 1'b0 : 1'b1;
endmodule

//--- testbench.sv
// Self-checking bench for the reset and watchdog supervisor
`timescale 1ns/1ns
module testbench;
   localparam int PD  = 16;
   localparam int TO  = (2 ** rwsup_pkg::WD_EXP0) * 74 / 10;
   localparam int WIN = rwsup_pkg::WD_WIN_CYC * 74 / 10;
   localparam int RST = rwsup_pkg::WD_RST_CYC * 74 / 10;
   logic        clk = 1'b0, srst = 1'b1, sup_ok = 1'b0, ext_pull = 1'b0;
   logic        rc_clk, pin_n, oe, out_n, osc_en, run, io_def, irq;
   logic [15:0] fetch;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   rwsup_pkg::rwsup_supply_t bo = '0;
   int          n_fail = 0, num_checks = 0, cyc = 0;
   rwsup_far_model rwsup_far_model_inst (.RESET_N_OE(oe), .ext_pull(ext_pull),
      .rc_clk(rc_clk), .pin_n(pin_n));
   rwsup_top #(.POR_DELAY(PD)) rwsup_top_inst (.REF_CLK(clk), .SRST(srst),
      .RC_CLK(rc_clk), .CORE_SUPPLY_OK(sup_ok), .RESET_N_IN(pin_n),
      .RESET_N_OUT(out_n), .RESET_N_OE(oe), .BO_LOW(bo), .RC_OSC_EN(osc_en),
      .CORE_RUN(run), .IO_DEFAULT(io_def), .FETCH_ADDR(fetch), .IRQ(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      if (n_fail == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_in(input int n, input int lo, input int hi);
      num_checks++;
      if (n < lo || n > hi)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h..%h", $time, n, lo,
            hi);
      end
   endtask
   function automatic logic sig(input int k);
      return k == 0 ? oe : k == 1 ? irq : run;
   endfunction
   task automatic wait_lvl(input int k, input logic v, output int n);
      n = 0;
      while (sig(k) !== v)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      rsp = bresp;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd = rdata;
      rsp = rresp;
   endtask
   task automatic t_power_on();
      int n;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (10) @(posedge clk);
      chk(pin_n, 1'b0);
      sup_ok <= 1'b1;
      wait_lvl(0, 1'b0, n);
      chk_in(n, PD - 1, PD + 3);
      wait_lvl(2, 1'b1, n);
      chk({out_n, osc_en, fetch}, {1'b0, 1'b1, 16'h8000});
      rd_reg(rwsup_pkg::ADDR_RST_CAUSE);
      chk(rd[rwsup_pkg::CAUSE_POR], 1'b1);
      rd_reg(rwsup_pkg::ADDR_SYS_CTRL);
      chk(rd, rwsup_pkg::SC_RESET);
   endtask
   task automatic t_bus();
      rd_reg(8'h20);
      chk(rsp, 2'b10);
      chk(rd, 32'h0);
      wr(8'h22, 32'h0);
      chk(rsp, 2'b10);
      wr(rwsup_pkg::ADDR_IRQ_MASK, 32'hf);
      rd_reg(rwsup_pkg::ADDR_IRQ_MASK);
      chk(rd, 32'hf);
   endtask
   task automatic t_brownout();
      wr(rwsup_pkg::ADDR_BO_CTRL, 32'h0);
      bo <= 3'b111;
      repeat (4) @(posedge clk);
      rd_reg(rwsup_pkg::ADDR_IRQ_STAT);
      chk(rd, 32'h0);
      bo <= 3'b000;
      for (int i = 0; i < 3; i++)
      begin
         wr(rwsup_pkg::ADDR_BO_CTRL, 32'h4 >> i);
         wr(rwsup_pkg::ADDR_IRQ_STAT, 32'hf);
         wr(rwsup_pkg::ADDR_IRQ_MASK, 32'hf);
         bo <= 3'b100 >> i;
         repeat (4) @(posedge clk);
         rd_reg(rwsup_pkg::ADDR_IRQ_STAT);
         chk(rd, 32'h2 << i);
         chk(irq, 1'b1);
         wr(rwsup_pkg::ADDR_IRQ_MASK, 32'h0);
         @(posedge clk);
         chk(irq, 1'b0);
         bo <= 3'b000;
         repeat (3) @(posedge clk);
         wr(rwsup_pkg::ADDR_IRQ_STAT, 32'h2 << i);
         rd_reg(rwsup_pkg::ADDR_IRQ_STAT);
         chk(rd, 32'h0);
      end
   endtask
   task automatic t_sw_reset();
      int n;
      wr(rwsup_pkg::ADDR_SYS_CTRL, 32'h3);
      repeat (4) @(posedge clk);
      chk(run, 1'b1);
      rd_reg(rwsup_pkg::ADDR_RST_CAUSE);
      chk(rd[rwsup_pkg::CAUSE_SW], 1'b0);
      wr(rwsup_pkg::ADDR_DEBUG_FLG, 32'h1);
      wr(rwsup_pkg::ADDR_SYS_CTRL, 32'h3);
      repeat (3) @(posedge clk);
      wait_lvl(2, 1'b1, n);
      rd_reg(rwsup_pkg::ADDR_RST_CAUSE);
      chk(rd[rwsup_pkg::CAUSE_SW], 1'b1);
      rd_reg(rwsup_pkg::ADDR_DEBUG_FLG);
      chk(rd, 32'h0);
   endtask
   task automatic t_ext_reset();
      int n;
      // Too short on purpose: must not count as a reset
      ext_pull <= 1'b1;
      repeat (3) @(posedge clk);
      ext_pull <= 1'b0;
      repeat (10) @(posedge clk);
      rd_reg(rwsup_pkg::ADDR_RST_CAUSE);
      chk(rd[rwsup_pkg::CAUSE_EXT], 1'b0);
      ext_pull <= 1'b1;
      repeat (10) @(posedge clk);
      chk(io_def, 1'b1);
      ext_pull <= 1'b0;
      wait_lvl(2, 1'b1, n);
      rd_reg(rwsup_pkg::ADDR_RST_CAUSE);
      chk(rd[rwsup_pkg::CAUSE_EXT], 1'b1);
   endtask
   task automatic t_watchdog();
      int n;
      wr(rwsup_pkg::ADDR_IRQ_MASK, 32'h1);
      wr(rwsup_pkg::ADDR_WD_CTRL, 32'h3);
      wait_lvl(1, 1'b1, n);
      chk_in(n, TO - 60, TO + 60);
      // Restart inside the window; a missed cancel resets and kills the irq
      wr(rwsup_pkg::ADDR_WD_RESTART, 32'h0);
      wr(rwsup_pkg::ADDR_IRQ_STAT, 32'h1);
      wait_lvl(1, 1'b1, n);
      chk_in(n, TO - 60, TO + 60);
      wait_lvl(0, 1'b1, n);
      chk_in(n, WIN - 20, WIN + 20);
      wait_lvl(0, 1'b0, n);
      chk_in(n, RST - 3, RST + 3);
      wait_lvl(2, 1'b1, n);
      rd_reg(rwsup_pkg::ADDR_RST_CAUSE);
      chk(rd[rwsup_pkg::CAUSE_WD], 1'b1);
   endtask
   initial
   begin
      t_power_on();
      t_bus();
      t_brownout();
      t_sw_reset();
      t_ext_reset();
      t_watchdog();
      conclude();
   end
endmodule
